/* File: src/mbx_pkg.sv */
// Package for the move and branch execution slice.
// Assumes a 14-bit instruction word and an 11-bit program counter.
package mbx_pkg;
    localparam int MBX_IW = 14;
    localparam int MBX_PCW = 11;
    localparam int MBX_SPW = 3;
    localparam int MBX_AW = 7;
    localparam int MBX_DW = 8;
    // Operation selector, decoded from the instruction word.
    typedef enum logic [2:0] {
        MBX_OP_NONE = 3'b000,
        MBX_OP_SFR_STORE = 3'b001,
        MBX_OP_LONG_CALL = 3'b010,
        MBX_OP_LONG_JUMP = 3'b011,
        MBX_OP_LOAD_IMM = 3'b100,
        MBX_OP_ACC_TO_REG = 3'b101,
        MBX_OP_REG_MOVE = 3'b110
    } mbx_op_t;
    localparam logic [3:0] MBX_SFR_MIN = 4'h5;
    localparam logic [3:0] MBX_SFR_MAX = 4'hF;
    localparam logic [MBX_PCW-1:0] MBX_PC_RESET = 11'h000;
    localparam logic [MBX_SPW-1:0] MBX_SP_RESET = 3'h0;
    localparam logic [MBX_DW-1:0] MBX_ACC_RESET = 8'h00;
    localparam logic [MBX_SPW-1:0] MBX_STACK_DEPTH = 3'h7;
    // Encodings: top bits of the instruction select the operation.
    localparam logic [2:0] MBX_ENC_CALL = 3'h4;
    localparam logic [2:0] MBX_ENC_JUMP = 3'h5;
    localparam logic [5:0] MBX_ENC_LOADI = 6'h0C;
    localparam logic [6:0] MBX_ENC_ACC2R = 7'h01;
    localparam logic [5:0] MBX_ENC_RMOVE = 6'h02;
    localparam logic [9:0] MBX_ENC_SFRST = 10'h001;
    localparam int MBX_Z_BIT = 2;
endpackage

/* File: src/mbx_dec_if.sv */
// Interface carrying decoded fields from decoder to execution top.
// Assumes a single clock domain; fields are combinational.
interface mbx_dec_if;
    mbx_pkg::mbx_op_t op;
    logic [mbx_pkg::MBX_PCW-1:0] target;
    logic [mbx_pkg::MBX_DW-1:0] imm;
    logic [mbx_pkg::MBX_AW-1:0] raddr;
    logic dest_reg;
    logic [3:0] sfr_sel;
    logic sfr_ok;
    modport dec (output op, target, imm, raddr, dest_reg, sfr_sel, sfr_ok);
    modport exe (input op, target, imm, raddr, dest_reg, sfr_sel, sfr_ok);
endinterface

/* File: src/mbx_decode.sv */
// Decoder for the move and branch slice of the instruction set.
// Assumes the instruction word is stable while it is presented.
module mbx_decode (
    input wire logic [mbx_pkg::MBX_IW-1:0] instr,
    mbx_dec_if.dec d
);
    // Field extraction; the operation is picked by fixed opcode prefixes.
    always_comb begin
        d.target = instr[10:0];
        d.imm = instr[7:0];
        d.raddr = instr[6:0];
        d.dest_reg = instr[7];
        d.sfr_sel = instr[3:0];
        d.sfr_ok = (instr[3:0] >= mbx_pkg::MBX_SFR_MIN) &&
                   (instr[3:0] <= mbx_pkg::MBX_SFR_MAX);
        if (instr[13:11] == mbx_pkg::MBX_ENC_CALL) begin
            d.op = mbx_pkg::MBX_OP_LONG_CALL;
        end else if (instr[13:11] == mbx_pkg::MBX_ENC_JUMP) begin
            d.op = mbx_pkg::MBX_OP_LONG_JUMP;
        end else if (instr[13:8] == mbx_pkg::MBX_ENC_LOADI) begin
            d.op = mbx_pkg::MBX_OP_LOAD_IMM;
        end else if (instr[13:7] == mbx_pkg::MBX_ENC_ACC2R) begin
            d.op = mbx_pkg::MBX_OP_ACC_TO_REG;
        end else if (instr[13:8] == mbx_pkg::MBX_ENC_RMOVE) begin
            d.op = mbx_pkg::MBX_OP_REG_MOVE;
        end else if (instr[13:4] == mbx_pkg::MBX_ENC_SFRST) begin
            d.op = mbx_pkg::MBX_OP_SFR_STORE;
        end else begin
            d.op = mbx_pkg::MBX_OP_NONE;
        end
    end
endmodule

/* File: src/mbx_exec.sv */
// Execution top for the move and branch slice of an 8-bit core.
// Assumes the fetch unit presents one instruction per cycle with instr_valid
// and that the data-memory read data is combinational on reg_raddr.
// Operation
// - The SFR store copies the accumulator to SFR F (5..15), accumulator kept.
// - Long call pushes the next address, bumps the stack pointer, two cycles.
// - Long call loads its 11-bit target into PC bits 10..0.
// - Long jump loads its 11-bit target into the PC and leaves the stack.
// - Load immediate puts an 8-bit constant into the accumulator, no flags.
// - Accumulator store writes the accumulator to data register 0..127.
// - Register move goes to the accumulator for d=0, back to R for d=1.
// - Register move sets zero when the moved value is zero, else clears it.
module mbx_exec (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [mbx_pkg::MBX_IW-1:0] instr,
    input wire logic instr_valid,
    input wire logic [mbx_pkg::MBX_DW-1:0] reg_rdata,
    input wire logic [mbx_pkg::MBX_DW-1:0] status_in,
    output logic [mbx_pkg::MBX_PCW-1:0] pc_q,
    output logic [mbx_pkg::MBX_DW-1:0] acc_q,
    output logic [mbx_pkg::MBX_SPW-1:0] sp_q,
    output logic [mbx_pkg::MBX_PCW-1:0] stack_top,
    output logic flush,
    output logic [mbx_pkg::MBX_AW-1:0] reg_raddr,
    output logic reg_we,
    output logic [mbx_pkg::MBX_AW-1:0] reg_waddr,
    output logic [mbx_pkg::MBX_DW-1:0] reg_wdata,
    output logic sfr_we,
    output logic [3:0] sfr_addr,
    output logic [mbx_pkg::MBX_DW-1:0] sfr_wdata,
    output logic status_we,
    output logic [mbx_pkg::MBX_DW-1:0] status_wdata
);
    mbx_dec_if dif ();
    logic discard_q;
    logic go;
    logic [mbx_pkg::MBX_PCW-1:0] stack_q [0:7];
    logic [mbx_pkg::MBX_PCW-1:0] pc_next;

    mbx_decode u_dec (
        .instr(instr),
        .d(dif.dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // An instruction executes unless it is the discarded fetch after a branch.
    assign go = instr_valid && !discard_q;
    assign reg_raddr = dif.raddr;
    assign stack_top = stack_q[sp_q];
    assign flush = discard_q;
    assign pc_next = pc_q + 11'h001;

    // Discard slot: the instruction behind a call or jump is dropped.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            discard_q <= 1'b0;
        end else begin
            discard_q <= go && (dif.op == mbx_pkg::MBX_OP_LONG_CALL ||
                                dif.op == mbx_pkg::MBX_OP_LONG_JUMP);
        end
    end

    // Program counter: branches load bits 10..0, else step by one.
    // The discarded slot leaves it alone, so the pc still names the branch
    // target when that instruction arrives and a call there pushes target+1.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pc_q <= mbx_pkg::MBX_PC_RESET;
        end else if (go) begin
            if (dif.op == mbx_pkg::MBX_OP_LONG_CALL ||
                dif.op == mbx_pkg::MBX_OP_LONG_JUMP) begin
                pc_q <= dif.target;
            end else begin
                pc_q <= pc_next;
            end
        end
    end

    // Return stack: a call pushes the following address; a jump leaves it.
    // Overflow wraps the pointer, as the stack depth is fixed and unchecked.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sp_q <= mbx_pkg::MBX_SP_RESET;
        end else if (go && dif.op == mbx_pkg::MBX_OP_LONG_CALL) begin
            sp_q <= sp_q + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (go && dif.op == mbx_pkg::MBX_OP_LONG_CALL) begin
            stack_q[sp_q + 3'h1] <= pc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator: only load immediate and register move with d=0 write it.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            acc_q <= mbx_pkg::MBX_ACC_RESET;
        end else if (go && dif.op == mbx_pkg::MBX_OP_LOAD_IMM) begin
            acc_q <= dif.imm;
        end else if (go && dif.op == mbx_pkg::MBX_OP_REG_MOVE &&
                     !dif.dest_reg) begin
            acc_q <= reg_rdata;
        end
    end

    // Data-memory and SFR write strobes, registered for one cycle.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_we <= 1'b0;
            reg_waddr <= 7'h00;
            reg_wdata <= 8'h00;
            sfr_we <= 1'b0;
            sfr_addr <= 4'h0;
            sfr_wdata <= 8'h00;
        end else begin
            reg_we <= 1'b0;
            sfr_we <= 1'b0;
            if (go && dif.op == mbx_pkg::MBX_OP_ACC_TO_REG) begin
                reg_we <= 1'b1;
                reg_waddr <= dif.raddr;
                reg_wdata <= acc_q;
            end else if (go && dif.op == mbx_pkg::MBX_OP_REG_MOVE &&
                         dif.dest_reg) begin
                reg_we <= 1'b1;
                reg_waddr <= dif.raddr;
                reg_wdata <= reg_rdata;
            end
            if (go && dif.op == mbx_pkg::MBX_OP_SFR_STORE && dif.sfr_ok) begin
                sfr_we <= 1'b1;
                sfr_addr <= dif.sfr_sel;
                sfr_wdata <= acc_q;
            end
        end
    end

    // Status: only the register move updates zero; other bits pass through.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            status_we <= 1'b0;
            status_wdata <= 8'h00;
        end else begin
            status_we <= go && dif.op == mbx_pkg::MBX_OP_REG_MOVE;
            status_wdata <= status_in;
            status_wdata[mbx_pkg::MBX_Z_BIT] <= (reg_rdata == 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_jump_pc;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_LONG_JUMP) |=>
            (pc_q == $past(dif.target)) && $stable(sp_q) && flush;
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump bad");

    property p_call;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_LONG_CALL) |=>
            (sp_q == $past(sp_q) + 3'h1) && (stack_top == $past(pc_q) + 11'h1);
    endproperty
    a_call: assert property (p_call) else $error("call push bad");

    property p_call_pc;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_LONG_CALL) |=>
            pc_q == $past(dif.target);
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call pc bad");

    property p_imm;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_LOAD_IMM) |=>
            acc_q == $past(dif.imm) && !status_we;
    endproperty
    a_imm: assert property (p_imm) else $error("imm bad");

    property p_store;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_ACC_TO_REG) |=>
            reg_we && reg_wdata == $past(acc_q) && acc_q == $past(acc_q);
    endproperty
    a_store: assert property (p_store) else $error("store bad");

    property p_sfr;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_SFR_STORE && dif.sfr_ok) |=>
            sfr_we && sfr_wdata == $past(acc_q) && acc_q == $past(acc_q) &&
            sfr_addr == $past(dif.sfr_sel);
    endproperty
    a_sfr: assert property (p_sfr) else $error("sfr store bad");

    property p_zero;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_REG_MOVE) |=> status_we &&
            status_wdata[mbx_pkg::MBX_Z_BIT] == ($past(reg_rdata) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag bad");

    property p_flags;
        @(posedge sys_clk) disable iff (!reset_n)
        status_we |-> $past(go && dif.op == mbx_pkg::MBX_OP_REG_MOVE);
    endproperty
    a_flags: assert property (p_flags) else $error("flag write bad");

    property p_move;
        @(posedge sys_clk) disable iff (!reset_n)
        (go && dif.op == mbx_pkg::MBX_OP_REG_MOVE && !dif.dest_reg) |=>
            acc_q == $past(reg_rdata) && !reg_we;
    endproperty
    a_move: assert property (p_move) else $error("move bad");

    property p_slot;
        @(posedge sys_clk) disable iff (!reset_n)
        flush |=> !flush && pc_q == $past(pc_q) && sp_q == $past(sp_q) &&
            acc_q == $past(acc_q) && !reg_we && !sfr_we && !status_we;
    endproperty
    a_slot: assert property (p_slot) else $error("slot bad");
endmodule

/* File: tb/mbx_exec_tb.sv */
// Self-checking testbench for the move and branch execution slice.
// Assumes the package and design files are compiled first; the bench plays
// the fetch unit, the data memory and the status register itself.
module mbx_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic instr_valid = 1'b0;
    logic [7:0] reg_rdata = 8'h00;
    logic [7:0] status_in = 8'h0B;
    logic [10:0] pc_q;
    logic [7:0] acc_q;
    logic [2:0] sp_q;
    logic [10:0] stack_top;
    logic flush;
    logic [6:0] reg_raddr;
    logic reg_we;
    logic [6:0] reg_waddr;
    logic [7:0] reg_wdata;
    logic sfr_we;
    logic [3:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic status_we;
    logic [7:0] status_wdata;
    int n_fail = 0;
    int comparisons = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and device under test.
    always #5 sys_clk = ~sys_clk;

    mbx_exec mbx_exec_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .instr(instr), .instr_valid(instr_valid), .reg_rdata(reg_rdata),
        .status_in(status_in), .pc_q(pc_q), .acc_q(acc_q), .sp_q(sp_q),
        .stack_top(stack_top), .flush(flush), .reg_raddr(reg_raddr),
        .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
        .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .status_we(status_we), .status_wdata(status_wdata));

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers; values are widened so one compare serves all fields.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One instruction: driven at an edge, taken at the next, judged later.
    task automatic exec(input logic [13:0] w);
        @(posedge sys_clk);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_load_imm();
        logic [10:0] p;
        p = pc_q;
        exec({mbx_pkg::MBX_ENC_LOADI, 8'hA5});
        check(acc_q, 8'hA5);
        check(status_we, 1'b0);
        check(pc_q, p + 11'h001);
        // An unknown word only steps the pc.
        p = pc_q;
        exec(14'h0000);
        check({acc_q, pc_q}, {8'hA5, p + 11'h001});
        check({reg_we, sfr_we, status_we}, 3'h0);
        $display("load immediate done");
    endtask

    task automatic t_acc_store();
        logic [7:0] a;
        a = acc_q;
        exec({mbx_pkg::MBX_ENC_ACC2R, 7'h7F});
        check({reg_we, 1'b0, reg_waddr, reg_wdata}, {2'b10, 7'h7F, a});
        check(acc_q, a);
        check(status_we, 1'b0);
        @(negedge sys_clk);
        check(reg_we, 1'b0);
        $display("accumulator store done");
    endtask

    // F below the legal range must not produce a write.
    task automatic t_sfr_store();
        logic [7:0] a;
        a = acc_q;
        for (int f = 4; f <= 15; f++) begin
            exec({mbx_pkg::MBX_ENC_SFRST, f[3:0]});
            check(sfr_we, f >= 5);
            if (f >= 5) check({sfr_addr, sfr_wdata}, {f[3:0], a});
            check(acc_q, a);
            check(status_we, 1'b0);
        end
        $display("sfr store done");
    endtask

    // Both destinations, with zero and non-zero data.
    task automatic t_reg_move();
        logic [7:0] v;
        logic [7:0] a;
        logic [7:0] e;
        logic d;
        for (int k = 0; k < 4; k++) begin
            v = (k[0]) ? 8'h3C : 8'h00;
            d = k[1];
            a = acc_q;
            @(posedge sys_clk);
            reg_rdata <= v;
            // An old zero bit that is set must be cleared by a non-zero move.
            status_in <= (k[0]) ? 8'hF4 : 8'h0B;
            exec({mbx_pkg::MBX_ENC_RMOVE, d, 7'h21});
            e = status_in;
            e[mbx_pkg::MBX_Z_BIT] = (v == 8'h00);
            check(reg_raddr, 7'h21);
            check(acc_q, d ? a : v);
            check(reg_we, d);
            if (d) check({reg_waddr, reg_wdata}, {7'h21, v});
            check({status_we, status_wdata}, {1'b1, e});
        end
        $display("register move done");
    endtask

    // Call to the top address; the instruction behind it must be dropped.
    task automatic t_call();
        logic [10:0] p;
        logic [2:0] s;
        logic [7:0] a;
        p = pc_q;
        s = sp_q;
        a = acc_q;
        @(posedge sys_clk);
        instr <= {mbx_pkg::MBX_ENC_CALL, 11'h7FF};
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr <= {mbx_pkg::MBX_ENC_LOADI, 8'h11};
        @(negedge sys_clk);
        check(pc_q, 11'h7FF);
        check({sp_q, stack_top}, {s + 3'h1, p + 11'h001});
        check(flush, 1'b1);
        check(status_we, 1'b0);
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
        check(acc_q, a);
        check({flush, pc_q}, {1'b0, 11'h7FF});
        $display("long call done");
    endtask

    task automatic t_jump();
        logic [2:0] s;
        logic [10:0] t;
        s = sp_q;
        t = stack_top;
        exec({mbx_pkg::MBX_ENC_JUMP, 11'h2AA});
        check(pc_q, 11'h2AA);
        check({sp_q, stack_top}, {s, t});
        check({flush, status_we}, 2'b10);
        $display("long jump done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and a watchdog that cuts a hang short.
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        check({pc_q, acc_q, sp_q}, 22'h000000);
        check({flush, reg_we, sfr_we, status_we}, 4'h0);
        t_load_imm();
        t_acc_store();
        t_sfr_store();
        t_reg_move();
        t_call();
        t_jump();
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
endmodule
